/* File: ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// serial controller
// ****
module ctrl_model (
  // pins
  output logic        sclk,
  output logic        cs,
  output logic        sdi,
  input  wire logic   sdo,
  input  wire logic   oe_n,
  // read result
  output logic [15:0] word,
  output logic        done
);
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  initial sclk = 1'b1;
  initial cs = 1'b0;
  initial word = 16'h0;
  initial done = 1'b0;
  // pull-down holds the line low when nobody drives it
  assign sdi = !oe_n ? sdo : (drv ? bit_q : 1'b0);
  task automatic frame(input logic use_cs, input logic [4:0] c, input logic [15:0] wd,
                       input logic ro, input int n);
    logic [20:0] sh;
    sh = {c, wd};
    done = 1'b0;
    cs = use_cs;
    #40;
    for (int k = 20; k > 20 - n; k--)
    begin
      sclk = 1'b0;
      drv = !ro && (k > 15 || c[4]);
      bit_q = sh[k];
      #32;
      sclk = 1'b1;
      if (k < 16)
        word[k] = sdi;
      #32;
    end
    drv = 1'b0;
    cs = 1'b0;
    done = (n == 21) && !c[4];
  endtask : frame
endmodule : ctrl_model
`default_nettype wire

/* File: encoder_out.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - wire_count_select low 3-wire, high 2-wire
// - frame is five command then sixteen data
// - line undriven during five command bits
// - all-zero command performs angle read
// - read word lock, agc, angle
// - 2-wire chain_port framing, ends on timeout
// - timeout 17 to 27 us resets interface
// - chain_port set first fall, cleared end
// - first command bit is read/write
// - pwm duty from stored angle
// - angle buffered per pwm period
// - pwm high pulse has minimum width
// - diagnostic pattern until one degree moved
// - invalid angle holds pwm low
// - quadrature a leads b clockwise
// - incremental mux modes and off
// - commutation sectors from angle and pole pairs
// - pole select 000 to 101 gives 1 to 6
// - pole select 111 drives uvw and pwm low
// - 2-wire reads and writes with clock and data
module encoder_out
  import encoder_out_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = encoder_out_pkg::TIMEOUT_CYCLES,
  parameter int unsigned PWM_DIV     = encoder_out_pkg::PWM_UNIT_CYCLES,
  parameter int unsigned PWM_MIN     = encoder_out_pkg::PWM_MIN_UNITS
)(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // serial pins
  input  wire logic                        wire_count_select,
  input  wire logic                        shift_clock,
  input  wire logic                        chip_select,
  input  wire logic                        serial_data_in,
  output logic                             serial_data_out,
  output logic                             serial_data_oe_n,
  output logic                             chain_port,
  // command results
  output logic [4:0]                       command_q_out,
  output logic                             command_strobe,
  output logic [15:0]                      write_data,
  output logic                             write_strobe,
  // angle source and settings
  input  wire encoder_out_pkg::sensor_sample_t sample,
  input  wire logic [8:0]                  zero_offset,
  input  wire logic [1:0]                  incremental_output_select,
  input  wire logic [2:0]                  commutation_pole_select,
  // position outputs
  output logic                             pwm_out,
  output encoder_out_pkg::incr_pins_t      incr_pins,
  output encoder_out_pkg::comm_pins_t      comm_pins
);
  import encoder_out_pkg::*;

  if (TIMEOUT_CYC < 2 || PWM_DIV < 1 || PWM_DIV > 65536 || PWM_MIN < 1 || PWM_MIN > 300)
  begin : g_check
    $error("encoder_out: parameter out of range");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] din_q;
  logic [1:0] wcs_q;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h0;
      din_q  <= 2'h0;
      wcs_q  <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], shift_clock};
      cs_q   <= {cs_q[0], chip_select};
      din_q  <= {din_q[0], serial_data_in};
      wcs_q  <= {wcs_q[0], wire_count_select};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];

  // ****************************************
  // serial frame engine
  // ****************************************
  ser_state_t  st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [4:0]  cmd_q, cmd_d;
  logic [15:0] sh_q, sh_d;
  logic        first_q, first_d;
  logic        drive_q, drive_d;
  logic        chain_q, chain_d;
  logic [31:0] to_q, to_d;
  logic        cstb_d, wstb_d, cstb_q, wstb_q;
  logic [15:0] wdat_q, wdat_d;
  logic        two_wire;
  logic        frame_reset;
  logic [15:0] read_word;

  // a pin like the others, so it is synchronised before use
  assign two_wire    = wcs_q[1];
  assign frame_reset = two_wire ? (to_q >= TIMEOUT_CYC) : ~cs_q[1];
  // only the angle read is served here; other read commands return zero
  assign read_word   = (cmd_q == CMD_ANGLE_READ) ?
    {sample.lock, sample.agc, sample.angle} : 16'h0000;

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    cmd_d   = cmd_q;
    sh_d    = sh_q;
    first_d = first_q;
    drive_d = drive_q;
    chain_d = chain_q;
    wdat_d  = wdat_q;
    cstb_d  = 1'b0;
    wstb_d  = 1'b0;
    to_d    = to_q;
    if (two_wire && st_q != SER_IDLE)
    begin
      // counted from the last rising edge so only a gap of TIMEOUT_CYC cycles between rises trips it
      to_d = sclk_rise ? 32'h0 : to_q + 32'h1;
    end
    if (st_q != SER_IDLE && frame_reset)
    begin
      st_d    = SER_IDLE;
      drive_d = 1'b0;
      chain_d = 1'b0;
      to_d    = 32'h0;
    end
    else
    begin
      case (st_q)
        SER_IDLE:
        begin
          cnt_d   = 5'h00;
          first_d = 1'b1;
          to_d    = 32'h0;
          if (two_wire && sclk_fall)
          begin
            st_d    = SER_CMD;
            chain_d = 1'b1;
          end
          else if (!two_wire && cs_q[1])
          begin
            st_d = SER_CMD;
          end
        end
        SER_CMD:
        begin
          if (sclk_rise)
          begin
            cmd_d = {cmd_q[3:0], din_q[1]};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(CMD_BITS - 1))
            begin
              st_d   = SER_DATA;
              cstb_d = 1'b1;
            end
          end
        end
        SER_DATA:
        begin
          if (sclk_fall && !cmd_q[RW_BIT_POS])
          begin
            drive_d = 1'b1;
            first_d = 1'b0;
            sh_d    = first_q ? read_word : {sh_q[14:0], 1'b0};
          end
          if (sclk_rise)
          begin
            cnt_d = cnt_q + 5'h01;
            if (cmd_q[RW_BIT_POS])
            begin
              sh_d = {sh_q[14:0], din_q[1]};
            end
            if (cnt_q == 5'(FRAME_BITS - 1))
            begin
              st_d    = SER_DONE;
              chain_d = 1'b0;
              if (cmd_q[RW_BIT_POS])
              begin
                wstb_d = 1'b1;
                wdat_d = {sh_q[14:0], din_q[1]};
              end
            end
          end
        end
        default:
        begin
          st_d = SER_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q    <= SER_IDLE;
      cnt_q   <= 5'h00;
      cmd_q   <= 5'h00;
      sh_q    <= 16'h0000;
      first_q <= 1'b1;
      drive_q <= 1'b0;
      chain_q <= 1'b0;
      to_q    <= 32'h0;
      cstb_q  <= 1'b0;
      wstb_q  <= 1'b0;
      wdat_q  <= 16'h0000;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cmd_q   <= cmd_d;
      sh_q    <= sh_d;
      first_q <= first_d;
      drive_q <= drive_d;
      chain_q <= chain_d;
      to_q    <= to_d;
      cstb_q  <= cstb_d;
      wstb_q  <= wstb_d;
      wdat_q  <= wdat_d;
    end
  end

  assign serial_data_out  = sh_q[15];
  assign serial_data_oe_n = ~drive_q;
  assign chain_port       = chain_q;
  assign command_q_out    = cmd_q;
  assign command_strobe   = cstb_q;
  assign write_data       = wdat_q;
  assign write_strobe     = wstb_q;

  // ****************************************
  // angle arithmetic
  // ****************************************
  logic [9:0]  corr_sum;
  logic [8:0]  corr;
  logic [11:0] elec_prod;
  logic [8:0]  elec;
  logic [2:0]  sector;

  assign corr_sum  = 10'(sample.angle) + 10'(ANGLE_STEPS) - 10'(zero_offset);
  assign corr      = (corr_sum >= 10'(ANGLE_STEPS)) ?
                     9'(corr_sum - 10'(ANGLE_STEPS)) : corr_sum[8:0];
  assign elec_prod = 12'(corr) * (12'(commutation_pole_select) + 12'h001);
  assign elec      = 9'(elec_prod % 12'(ANGLE_STEPS));
  assign sector    = 3'(elec / 9'(SECTOR_STEPS));

  // ****************************************
  // pwm output
  // ****************************************
  localparam int unsigned PWM_PERIOD = 2 * PWM_MIN + ANGLE_STEPS;

  logic [15:0] div_q, div_d;
  logic [9:0]  pcnt_q, pcnt_d;
  logic [9:0]  hlen_q, hlen_d;
  logic        diag_q, diag_d;
  logic        seen_q, seen_d;
  logic [8:0]  start_q, start_d;
  logic        pwm_q, pwm_d;
  logic        tick;

  assign tick = (div_q == 16'(PWM_DIV - 1));

  always_comb
  begin
    div_d   = tick ? 16'h0000 : div_q + 16'h0001;
    pcnt_d  = pcnt_q;
    hlen_d  = hlen_q;
    diag_d  = diag_q;
    seen_d  = seen_q;
    start_d = start_q;
    if (sample.valid && !seen_q)
    begin
      seen_d  = 1'b1;
      start_d = corr;
    end
    // any change of one step is one degree of movement
    if (seen_q && sample.valid && corr != start_q)
    begin
      diag_d = 1'b0;
    end
    if (tick)
    begin
      pcnt_d = (pcnt_q == 10'(PWM_PERIOD - 1)) ? 10'h000 : pcnt_q + 10'h001;
      if (pcnt_q == 10'(PWM_PERIOD - 1))
      begin
        // held for the whole period so the duty never glitches mid-cycle
        hlen_d = diag_q ? 10'(PWM_PERIOD / 2) :
                 10'(PWM_MIN) + 10'(corr);
      end
    end
    pwm_d = (pcnt_q < hlen_q) && sample.valid
            && (commutation_pole_select != UVW_OFF);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      div_q   <= 16'h0000;
      pcnt_q  <= 10'h000;
      // diagnostic pattern from the very first period after reset
      hlen_q  <= 10'(PWM_PERIOD / 2);
      diag_q  <= 1'b1;
      seen_q  <= 1'b0;
      start_q <= 9'h000;
      pwm_q   <= 1'b0;
    end
    else
    begin
      div_q   <= div_d;
      pcnt_q  <= pcnt_d;
      hlen_q  <= hlen_d;
      diag_q  <= diag_d;
      seen_q  <= seen_d;
      start_q <= start_d;
      pwm_q   <= pwm_d;
    end
  end

  assign pwm_out = pwm_q;

  // ****************************************
  // incremental and commutation outputs
  // ****************************************
  logic [8:0]  prev_q;
  logic        dir_q, dir_d;
  logic [3:0]  pw_q, pw_d;
  incr_pins_t  inc_q, inc_d;
  comm_pins_t  com_q, com_d;
  logic [1:0]  quad;

  assign quad = 2'(corr % 9'h004);

  always_comb
  begin
    dir_d = dir_q;
    pw_d  = (pw_q != 4'h0) ? pw_q - 4'h1 : 4'h0;
    if (corr != prev_q)
    begin
      // wrap from 359 to 0 counts as clockwise
      dir_d = (corr == 9'(prev_q + 9'h001)) || (prev_q == 9'(ANGLE_STEPS - 1) && corr == 9'h000);
      pw_d  = 4'(PULSE_CYCLES);
    end
    inc_d.i = (corr == 9'h000);
    case (incremental_output_select)
      ABI_QUAD:
      begin
        inc_d.b = quad[1];
        inc_d.a = (quad == 2'h1) || (quad == 2'h2);
      end
      ABI_STEP:
      begin
        inc_d.a = corr[0];
        inc_d.b = dir_q;
      end
      ABI_PULSE:
      begin
        inc_d.a = (pw_q != 4'h0);
        inc_d.b = dir_q;
      end
      default:
      begin
        inc_d = '0;
      end
    endcase
    case (sector)
      3'h0:    com_d = '{u: 1'b1, v: 1'b0, w: 1'b0};
      3'h1:    com_d = '{u: 1'b1, v: 1'b1, w: 1'b0};
      3'h2:    com_d = '{u: 1'b0, v: 1'b1, w: 1'b0};
      3'h3:    com_d = '{u: 1'b0, v: 1'b1, w: 1'b1};
      3'h4:    com_d = '{u: 1'b0, v: 1'b0, w: 1'b1};
      default: com_d = '{u: 1'b1, v: 1'b0, w: 1'b1};
    endcase
    if (commutation_pole_select == UVW_OFF || commutation_pole_select == 3'h6)
    begin
      com_d = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_q <= 9'h000;
      dir_q  <= 1'b1;
      pw_q   <= 4'h0;
      inc_q  <= '0;
      com_q  <= '0;
    end
    else
    begin
      prev_q <= corr;
      dir_q  <= dir_d;
      pw_q   <= pw_d;
      inc_q  <= inc_d;
      com_q  <= com_d;
    end
  end

  assign incr_pins = inc_q;
  assign comm_pins = com_q;

endmodule : encoder_out

`default_nettype wire

/* File: encoder_out_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module encoder_out_chk
  import encoder_out_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = 40,
  parameter int unsigned PWM_DIV     = 1,
  parameter int unsigned PWM_MIN     = 2
)(
  // clock and reset
  input wire logic                           clock,
  input wire logic                           rst,
  // serial pins
  input wire logic                           wire_count_select,
  input wire logic                           shift_clock,
  input wire logic                           chip_select,
  input wire logic                           serial_data_in,
  input wire logic                           serial_data_out,
  input wire logic                           serial_data_oe_n,
  input wire logic                           chain_port,
  // command results
  input wire logic [4:0]                     command_q_out,
  input wire logic                           command_strobe,
  input wire logic [15:0]                    write_data,
  input wire logic                           write_strobe,
  // angle and settings
  input wire encoder_out_pkg::sensor_sample_t sample,
  input wire logic [8:0]                     zero_offset,
  input wire logic [1:0]                     incremental_output_select,
  input wire logic [2:0]                     commutation_pole_select,
  // outputs
  input wire logic                           pwm_out,
  input wire encoder_out_pkg::incr_pins_t    incr_pins,
  input wire encoder_out_pkg::comm_pins_t    comm_pins
);
  logic        sclk_q, sclk_d;
  logic [15:0] idle_q, idle_d;
  logic [15:0] hi_q, hi_d;
  // idle counts from any edge: the first fall of a frame comes before any rise
  always_comb
  begin
    sclk_d = shift_clock;
    idle_d = (shift_clock != sclk_q) ? 16'h0 : idle_q + 16'(idle_q != 16'hffff);
    hi_d   = pwm_out ? hi_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge clock)
  begin
    sclk_q <= sclk_d;
    idle_q <= rst ? 16'h0 : idle_d;
    hi_q   <= rst ? 16'h0 : hi_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_cs_float: assert property ((!wire_count_select && !chip_select) [*5] |-> serial_data_oe_n)
    else $error("line driven with chip select low");
  a_chain_3w: assert property (!wire_count_select [*8] |-> !chain_port)
    else $error("chain port set in 3-wire mode");
  a_cmd_float: assert property (command_strobe |-> serial_data_oe_n)
    else $error("line driven during command bits");
  a_wr_bit: assert property (write_strobe |-> command_q_out[RW_BIT_POS])
    else $error("write without write command bit");
  a_wr_float: assert property (write_strobe |-> serial_data_oe_n)
    else $error("line driven in write frame");
  a_uvw_off: assert property ((commutation_pole_select == UVW_OFF) [*3]
    |-> comm_pins == '0 && !pwm_out)
    else $error("uvw or pwm not low when off");
  a_abi_off: assert property ((incremental_output_select == 2'h3) [*3] |-> incr_pins == '0)
    else $error("incremental pins not low when off");
  a_pwm_inval: assert property (!sample.valid [*3] |-> !pwm_out)
    else $error("pwm high on invalid angle");
  a_pwm_min: assert property ($fell(pwm_out) && sample.valid && commutation_pole_select < 3'h6
    |-> hi_q >= 16'(PWM_DIV * PWM_MIN))
    else $error("pwm pulse too narrow");
  a_time_out: assert property (wire_count_select && idle_q > 16'(TIMEOUT_CYC + 8)
    |-> !chain_port && serial_data_oe_n)
    else $error("2-wire interface not reset after timeout");
  c_cmd_2w: cover property (command_strobe && wire_count_select);
  c_write: cover property (write_strobe);
  c_pwm: cover property ($fell(pwm_out));
endmodule : encoder_out_chk

bind encoder_out encoder_out_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .PWM_DIV(PWM_DIV),
  .PWM_MIN(PWM_MIN)) i_encoder_out_chk (.clock, .rst, .wire_count_select, .shift_clock,
  .chip_select, .serial_data_in, .serial_data_out, .serial_data_oe_n, .chain_port,
  .command_q_out, .command_strobe, .write_data, .write_strobe, .sample, .zero_offset,
  .incremental_output_select, .commutation_pole_select, .pwm_out, .incr_pins, .comm_pins);
`default_nettype wire

/* File: encoder_out_pkg.sv */
package encoder_out_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned CMD_BITS        = 5;
  localparam int unsigned DATA_BITS       = 16;
  localparam int unsigned FRAME_BITS      = CMD_BITS + DATA_BITS;
  localparam int unsigned RW_BIT_POS      = 4;
  localparam logic [4:0]  CMD_ANGLE_READ  = 5'h00;
  localparam int unsigned LOCK_POS        = 15;
  localparam int unsigned AGC_LSB         = 9;
  localparam int unsigned AGC_BITS        = 6;
  localparam int unsigned ANGLE_BITS      = 9;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLOCK_PERIOD_NS = 4;
  localparam int unsigned TIMEOUT_MIN_US  = 17;
  localparam int unsigned TIMEOUT_MAX_US  = 27;
  localparam int unsigned TIMEOUT_CYCLES  =
    (TIMEOUT_MIN_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned PWM_UNIT_CYCLES = 250;
  localparam int unsigned PWM_MIN_UNITS   = 12;
  localparam int unsigned PULSE_CYCLES    = 8;

  // ****************************************
  // angle and field selects
  // ****************************************
  localparam int unsigned ANGLE_STEPS     = 360;
  localparam int unsigned SECTOR_STEPS    = 60;
  localparam int unsigned ABI_LSB         = 12;
  localparam int unsigned UVW_LSB         = 9;
  localparam logic [1:0]  ABI_QUAD        = 2'h0;
  localparam logic [1:0]  ABI_STEP        = 2'h1;
  localparam logic [1:0]  ABI_PULSE       = 2'h2;
  localparam logic [1:0]  ABI_RESET       = 2'h0;
  localparam logic [2:0]  UVW_OFF         = 3'h7;
  localparam logic [2:0]  UVW_RESET       = 3'h0;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD  = 2'b01,
    SER_DATA = 2'b10,
    SER_DONE = 2'b11
  } ser_state_t;

  typedef struct packed {
    logic       valid;
    logic       lock;
    logic [5:0] agc;
    logic [8:0] angle;
  } sensor_sample_t;

  typedef struct packed {
    logic a;
    logic b;
    logic i;
  } incr_pins_t;

  typedef struct packed {
    logic u;
    logic v;
    logic w;
  } comm_pins_t;

endpackage : encoder_out_pkg

/* File: tb_encoder_out.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb_encoder_out;
  import encoder_out_pkg::*;
  localparam int unsigned TO = 40;
  localparam int unsigned PDIV = 1;
  localparam int unsigned PMIN = 2;
  localparam int unsigned PER = (2 * PMIN + ANGLE_STEPS) * PDIV;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wire_count_select = 1'b0;
  sensor_sample_t smp;
  logic [8:0] zo = 9'h00a;
  logic [1:0] abi = 2'h0;
  logic [2:0] uvw = 3'h0;
  logic sclk, cs, sdi, sdo, oe_n, chain, command_strobe, write_strobe, pwm_out, done;
  logic [4:0] cmd_out;
  logic [15:0] write_data, word, n;
  incr_pins_t incr_pins;
  comm_pins_t comm_pins;
  logic [15:0] q_cmd[$], q_wr[$], q_rd[$];
  logic [2:0] tbl [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  int n_errors = 0;
  int comparisons = 0;
  always #2 clock = ~clock;
  encoder_out #(.TIMEOUT_CYC(TO), .PWM_DIV(PDIV), .PWM_MIN(PMIN)) i_encoder_out (
    .clock, .rst, .wire_count_select, .shift_clock(sclk), .chip_select(cs),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_n(oe_n),
    .chain_port(chain), .command_q_out(cmd_out), .command_strobe, .write_data,
    .write_strobe, .sample(smp), .zero_offset(zo), .incremental_output_select(abi),
    .commutation_pole_select(uvw), .pwm_out, .incr_pins, .comm_pins);
  ctrl_model i_ctrl_model (.sclk, .cs, .sdi, .sdo, .oe_n, .word, .done);
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t word exp %h got %h", $time, e, g);
    end
  endtask : cmp_word
  task automatic cmp_pins(input logic [2:0] e, input logic [2:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t pins exp %b got %b", $time, e, g);
    end
  endtask : cmp_pins
  // results arrive in frame order, so one queue per kind is enough
  // sampled mid-cycle so a registered strobe is seen settled
  always @(negedge clock)
  begin
    if (command_strobe === 1'b1)
      cmp_word(q_cmd.pop_front(), {11'h0, cmd_out});
    if (write_strobe === 1'b1)
      cmp_word(q_wr.pop_front(), write_data);
  end
  always @(posedge done) cmp_word(q_rd.pop_front(), word);
  task automatic ser(input logic tw, input logic [4:0] c, input logic ro, input int nb);
    logic [15:0] wd;
    wd = 16'($urandom);
    q_cmd.push_back({11'h0, c});
    if (c[4])
      q_wr.push_back(wd);
    else if (nb == 21)
      q_rd.push_back(c == CMD_ANGLE_READ ? {smp.lock, smp.agc, smp.angle} : 16'h0);
    i_ctrl_model.frame(!tw, c, wd, ro, nb);
    #400;
  endtask : ser
  task automatic pwm_meas(input logic [8:0] nx, output logic [15:0] h);
    int k;
    k = 0;
    h = 0;
    while (pwm_out === 1'b1 && k < 1000)
    begin
      @(negedge clock);
      k++;
    end
    while (pwm_out !== 1'b1 && k < 2000)
    begin
      @(negedge clock);
      k++;
    end
    smp.angle = nx;
    while (pwm_out === 1'b1 && h < 1000)
    begin
      @(negedge clock);
      h++;
    end
  endtask : pwm_meas
  task automatic pwm_quiet(output logic [15:0] h);
    h = 0;
    repeat (800)
    begin
      @(negedge clock);
      h = h + 16'(pwm_out !== 1'b0);
    end
  endtask : pwm_quiet
  task automatic set_ang(input logic [8:0] a);
    @(negedge clock);
    smp.angle = a;
    repeat (3) @(negedge clock);
  endtask : set_ang
  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    logic [2:0] e, mk;
    int a, q, s;
    void'($urandom(98));
    smp = '{1'b1, 1'b1, 6'($urandom), 9'h00a};
    repeat (12) @(negedge clock);
    rst = 1'b0;
    pwm_meas(9'h00a, n);
    cmp_word(16'(PER / 2), n);
    pwm_meas(9'h00b, n);
    pwm_meas(9'h005, n);
    cmp_word(16'((PMIN + 1) * PDIV), n);
    pwm_meas(9'h00a, n);
    cmp_word(16'((PMIN + 355) * PDIV), n);
    pwm_meas(9'h00a, n);
    cmp_word(16'(PMIN * PDIV), n);
    smp.valid = 1'b0;
    pwm_quiet(n);
    cmp_word(16'h0, n);
    smp.valid = 1'b1;
    zo = 9'h000;
    for (int m = 0; m < 2; m++)
    begin
      @(negedge clock);
      wire_count_select = m[0];
      #100;
      ser(m[0], 5'h00, 1'b1, 21);
      ser(m[0], 5'h00, 1'b1, 8);
      ser(m[0], 5'h00, 1'b0, 21);
      ser(m[0], 5'h04, 1'b0, 21);
      ser(m[0], 5'h17, 1'b0, 21);
    end
    for (int md = 0; md < 4; md++)
    begin
      abi = md[1:0];
      for (a = 0; a < 8; a++)
      begin
        set_ang(a[8:0]);
        q = a % 4;
        e = {md == 1 ? a[0] : (q == 1 || q == 2), q[1], a == 0};
        mk = md == 2 ? 3'h1 : (md == 1 ? 3'h5 : 3'h7);
        cmp_pins(md == 3 ? 3'h0 : e & mk, incr_pins & mk);
      end
    end
    for (int p = 0; p < 8; p++)
    begin
      if (p != 6)
      begin
        uvw = p[2:0];
        a = $urandom % 360;
        set_ang(a[8:0]);
        s = (a * (p + 1)) % 360 / 60;
        cmp_pins(p == 7 ? 3'h0 : tbl[s], comm_pins);
      end
    end
    pwm_quiet(n);
    cmp_word(16'h0, n);
    wrap_up();
  end
endmodule : tb_encoder_out
`default_nettype wire
